// ==== ptp_pad_model.sv ====
// Pad model: board drivers, pull devices and floating pins
`timescale 1ns/100ps

module ptp_pad_model (
  // Clock
  input  wire logic       clk,
  // Device side
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pin_pull_up_en,
  input  wire logic [7:0] pin_pull_down_en,
  // Board side
  input  wire logic [7:0] ext_drive,
  input  wire logic [7:0] ext_en,
  output logic      [7:0] pin_level
);
  logic [7:0] float_r = 8'h00;

  // A floating pin toggles every cycle so no stale level can pass for a real one
  always_ff @(posedge clk) begin
    float_r <= ~float_r;
  end

  // Board drive wins over the pad, as a short would
  assign pin_level = (ext_en & ext_drive)
                   | (~ext_en & pin_oe & pin_out)
                   | (~ext_en & ~pin_oe & (pin_pull_up_en | (~pin_pull_down_en & float_r)));

endmodule : ptp_pad_model

// ==== ptp_pkg.sv ====
// Register map, reset values and field layout of the port T pin controller
package ptp_pkg;

  // Register widths
  localparam int unsigned ADDR_W           = 8;
  localparam int unsigned DATA_W           = 8;
  localparam int unsigned PIN_W            = 8;
  localparam int unsigned ROUTE_W          = 5;
  localparam int unsigned TIMER_ACTION_W   = 2 * PIN_W;

  // Register offsets, byte addresses on the plain register port
  localparam logic [7:0] OFS_OUTPUT_LATCH   = 8'h00;
  localparam logic [7:0] OFS_PIN_LEVEL      = 8'h01;
  localparam logic [7:0] OFS_DIRECTION      = 8'h02;
  localparam logic [7:0] OFS_DRIVE_STRENGTH = 8'h03;
  localparam logic [7:0] OFS_PULL_ON        = 8'h04;
  localparam logic [7:0] OFS_PULL_POLARITY  = 8'h05;
  localparam logic [7:0] OFS_ROUTING        = 8'h07;
  localparam logic [7:0] OFS_INT_ENABLE     = 8'h10;
  localparam logic [7:0] OFS_INT_STATUS     = 8'h11;

  // Values after reset
  localparam logic [7:0] RST_OUTPUT_LATCH   = 8'h00;
  localparam logic [7:0] RST_DIRECTION      = 8'h00;
  localparam logic [7:0] RST_DRIVE_STRENGTH = 8'h00;
  localparam logic [7:0] RST_PULL_ON        = 8'h00;
  localparam logic [7:0] RST_PULL_POLARITY  = 8'h00;
  localparam logic [4:0] RST_ROUTING        = 5'h00;
  localparam logic [7:0] RST_INT_ENABLE     = 8'h00;
  localparam logic [7:0] RST_INT_STATUS     = 8'h00;
  localparam logic [7:0] RST_PIN_SAMPLE     = 8'h00;
  localparam logic [7:0] RST_READ_DATA      = 8'h00;

  // Value read back from an unmapped offset
  localparam logic [7:0] UNMAPPED_READ      = 8'h00;

  // Field positions
  localparam int unsigned TIMER_GLOBAL_EN_BIT = 7;
  localparam int unsigned ROUTED_PIN_MSB      = 4;

  // Timer output action code meaning "pin disconnected from the timer"
  localparam logic [1:0] TIMER_ACTION_OFF   = 2'h0;

  // Cycles from pin edge to readable level (two synchroniser flops)
  localparam int unsigned SYNC_STAGES       = 2;

  // Pin ownership, one-hot
  typedef enum logic [2:0] {
    PTP_OWN_GPIO  = 3'h1,
    PTP_OWN_TIMER = 3'h2,
    PTP_OWN_PWM   = 3'h4
  } ptp_owner_t;

endpackage : ptp_pkg

// ==== ptp_port_t.sv ====
// Port T pin controller: registers, pin muxing, pulls, drive and edge interrupts
//
// How it works
// - Pull select chooses interrupt edge when enabled
// - Input pull: select 0 up, 1 down
// - Output drives latch level, pull forced off
// - Select 0 falling, 1 rising, any direction
// - Register reads are registered on the clock
// - Data read: latch if output, else pin
// - Timer output channel takes over its pin
// - Pins 4-0: PWM, then timer, then latch
// - Timer active: enabled, compare/toggle, output action not off
// - Pin level read always; writes ignored
// - Direction bit 0 input, 1 output
// - Owned pin forced output, direction kept
// - Direction bit rules again after release
// - Capture input always sees the pin
// - Reduced drive only matters on outputs
// - All pull devices off after reset
// - Routing bit 0 timer, 1 PWM
//
// Our own choice: the plain strobed port.
`timescale 1ns/100ps

module ptp_port_t #(
  parameter int unsigned PIN_W   = ptp_pkg::PIN_W,
  parameter int unsigned ROUTE_W = ptp_pkg::ROUTE_W
) (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          sys_rst,

  // Register port
  input  wire logic [ptp_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic [ptp_pkg::DATA_W-1:0]    reg_wr_data,
  input  wire logic                          reg_wr_en,
  input  wire logic                          reg_rd_en,
  output logic      [ptp_pkg::DATA_W-1:0]    reg_rd_data,

  // Timer module controls and channel outputs
  input  wire logic [ptp_pkg::DATA_W-1:0]    timer_system_control,
  input  wire logic [PIN_W-1:0]              timer_compare_select,
  input  wire logic [PIN_W-1:0]              timer_overflow_toggle,
  input  wire logic [PIN_W-1:0]              timer_output_action_high,
  input  wire logic [PIN_W-1:0]              timer_output_action_low,
  input  wire logic [PIN_W-1:0]              timer_channel_out,
  output logic      [PIN_W-1:0]              timer_capture_in,

  // PWM module channel enables and outputs
  input  wire logic [ROUTE_W-1:0]            pwm_channel_enable,
  input  wire logic [ROUTE_W-1:0]            pwm_channel_out,

  // Pads
  input  wire logic [PIN_W-1:0]              pin_in,
  output logic      [PIN_W-1:0]              pin_out,
  output logic      [PIN_W-1:0]              pin_oe,
  output logic      [PIN_W-1:0]              pin_reduced_drive,
  output logic      [PIN_W-1:0]              pin_pull_up_en,
  output logic      [PIN_W-1:0]              pin_pull_down_en,

  // Interrupt
  output logic                               irq
);

  // Software registers
  logic [PIN_W-1:0]   output_latch_r;
  logic [PIN_W-1:0]   direction_r;
  logic [PIN_W-1:0]   drive_strength_r;
  logic [PIN_W-1:0]   pull_on_r;
  logic [PIN_W-1:0]   pull_polarity_r;
  logic [ROUTE_W-1:0] routing_r;
  logic [PIN_W-1:0]   interrupt_enable_r;
  logic [PIN_W-1:0]   int_status_r;
  logic [PIN_W-1:0]   int_status_nxt;

  // Pin sampling
  logic [PIN_W-1:0]   pin_meta_r;
  logic [PIN_W-1:0]   pin_sync_r;
  logic [PIN_W-1:0]   pin_prev_r;

  // Pin function selection
  logic [PIN_W-1:0]   timer_active;
  logic [PIN_W-1:0]   pwm_owns;
  logic [PIN_W-1:0]   drive_level;
  logic [PIN_W-1:0]   drive_enable;
  logic [PIN_W-1:0]   edge_event;
  ptp_pkg::ptp_owner_t owner [PIN_W];

  // Bus decode
  logic               wr_latch;
  logic               wr_direction;
  logic               wr_drive;
  logic               wr_pull_on;
  logic               wr_pull_pol;
  logic               wr_routing;
  logic               wr_int_enable;
  logic               wr_int_status;
  logic [ptp_pkg::DATA_W-1:0] rd_value;

  // Timer channel drives its pin when the timer runs, the channel compares
  // or toggles on overflow, and its output action connects it to the pin.
  function automatic logic timer_drives(
    input logic       global_en,
    input logic       compare,
    input logic       ovf_toggle,
    input logic [1:0] action
  );
    timer_drives = global_en && (compare || ovf_toggle)
                   && (action != ptp_pkg::TIMER_ACTION_OFF);
  endfunction : timer_drives

  // Narrows a bus word to a register of PIN_W bits
  function automatic logic [PIN_W-1:0] to_pins(input logic [ptp_pkg::DATA_W-1:0] word);
    to_pins = word[PIN_W-1:0];
  endfunction : to_pins

  // Widens a PIN_W register to a bus word, upper bits zero
  function automatic logic [ptp_pkg::DATA_W-1:0] to_word(input logic [PIN_W-1:0] bits);
    logic [ptp_pkg::DATA_W-1:0] w;
    w = '0;
    w[PIN_W-1:0] = bits;
    to_word = w;
  endfunction : to_word

  // ---------------------------------------------------------------
  // Write decode. The pin level register has no write enable at all.
  // ---------------------------------------------------------------
  always_comb begin
    wr_latch      = reg_wr_en && (reg_addr == ptp_pkg::OFS_OUTPUT_LATCH);
    wr_direction  = reg_wr_en && (reg_addr == ptp_pkg::OFS_DIRECTION);
    wr_drive      = reg_wr_en && (reg_addr == ptp_pkg::OFS_DRIVE_STRENGTH);
    wr_pull_on    = reg_wr_en && (reg_addr == ptp_pkg::OFS_PULL_ON);
    wr_pull_pol   = reg_wr_en && (reg_addr == ptp_pkg::OFS_PULL_POLARITY);
    wr_routing    = reg_wr_en && (reg_addr == ptp_pkg::OFS_ROUTING);
    wr_int_enable = reg_wr_en && (reg_addr == ptp_pkg::OFS_INT_ENABLE);
    wr_int_status = reg_wr_en && (reg_addr == ptp_pkg::OFS_INT_STATUS);
  end

  // Output latch
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      output_latch_r <= to_pins(ptp_pkg::RST_OUTPUT_LATCH);
    end else if (wr_latch) begin
      output_latch_r <= to_pins(reg_wr_data);
    end
  end

  // Direction; never altered by timer or PWM ownership
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      direction_r <= to_pins(ptp_pkg::RST_DIRECTION);
    end else if (wr_direction) begin
      direction_r <= to_pins(reg_wr_data);
    end
  end

  // Drive strength
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      drive_strength_r <= to_pins(ptp_pkg::RST_DRIVE_STRENGTH);
    end else if (wr_drive) begin
      drive_strength_r <= to_pins(reg_wr_data);
    end
  end

  // Pull enable and pull polarity
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pull_on_r       <= to_pins(ptp_pkg::RST_PULL_ON);
      pull_polarity_r <= to_pins(ptp_pkg::RST_PULL_POLARITY);
    end else begin
      if (wr_pull_on) begin
        pull_on_r <= to_pins(reg_wr_data);
      end
      if (wr_pull_pol) begin
        pull_polarity_r <= to_pins(reg_wr_data);
      end
    end
  end

  // Module routing for the low pins
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      routing_r <= ptp_pkg::RST_ROUTING;
    end else if (wr_routing) begin
      routing_r <= reg_wr_data[ROUTE_W-1:0];
    end
  end

  // Interrupt enable, also the mask onto irq
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      interrupt_enable_r <= to_pins(ptp_pkg::RST_INT_ENABLE);
    end else if (wr_int_enable) begin
      interrupt_enable_r <= to_pins(reg_wr_data);
    end
  end

  // ---------------------------------------------------------------
  // Pin sampling: two flops before any logic, a third for edges.
  // The first flop feeds the second only.
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_meta_r <= to_pins(ptp_pkg::RST_PIN_SAMPLE);
      pin_sync_r <= to_pins(ptp_pkg::RST_PIN_SAMPLE);
    end else begin
      pin_meta_r <= pin_in;
      pin_sync_r <= pin_meta_r;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_prev_r <= to_pins(ptp_pkg::RST_PIN_SAMPLE);
    end else begin
      pin_prev_r <= pin_sync_r;
    end
  end

  // Capture input follows the pin whatever owns it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      timer_capture_in <= to_pins(ptp_pkg::RST_PIN_SAMPLE);
    end else begin
      timer_capture_in <= pin_sync_r;
    end
  end

  // ---------------------------------------------------------------
  // Pin function selection
  // ---------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < PIN_W; i++) begin
      timer_active[i] = timer_drives(
        timer_system_control[ptp_pkg::TIMER_GLOBAL_EN_BIT],
        timer_compare_select[i],
        timer_overflow_toggle[i],
        {timer_output_action_high[i], timer_output_action_low[i]});
      // Only the low pins can be routed to PWM
      if (i < ROUTE_W) begin
        pwm_owns[i] = routing_r[i] && pwm_channel_enable[i];
      end else begin
        pwm_owns[i] = 1'b0;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < PIN_W; i++) begin
      if (pwm_owns[i]) begin
        owner[i] = ptp_pkg::PTP_OWN_PWM;
      end else if (timer_active[i]) begin
        owner[i] = ptp_pkg::PTP_OWN_TIMER;
      end else begin
        owner[i] = ptp_pkg::PTP_OWN_GPIO;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < PIN_W; i++) begin
      drive_level[i]  = output_latch_r[i];
      drive_enable[i] = direction_r[i];
      unique case (owner[i])
        ptp_pkg::PTP_OWN_PWM: begin
          if (i < ROUTE_W) begin
            drive_level[i] = pwm_channel_out[i];
          end
          drive_enable[i] = 1'b1;
        end
        ptp_pkg::PTP_OWN_TIMER: begin
          drive_level[i]  = timer_channel_out[i];
          drive_enable[i] = 1'b1;
        end
        ptp_pkg::PTP_OWN_GPIO: begin
          drive_level[i]  = output_latch_r[i];
          drive_enable[i] = direction_r[i];
        end
      endcase
    end
  end

  // Pad controls, registered so the pads see clean levels. Pulls follow
  // the effective direction: a pin seized by the timer loses its pull too.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_out           <= '0;
      pin_oe            <= '0;
      pin_reduced_drive <= '0;
    end else begin
      pin_out           <= drive_level;
      pin_oe            <= drive_enable;
      pin_reduced_drive <= drive_strength_r & drive_enable;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_pull_up_en   <= '0;
      pin_pull_down_en <= '0;
    end else begin
      pin_pull_up_en   <= pull_on_r & ~pull_polarity_r & ~drive_enable;
      pin_pull_down_en <= pull_on_r & pull_polarity_r & ~drive_enable;
    end
  end

  // ---------------------------------------------------------------
  // Edge interrupts on the synchronised level, any direction.
  // A new edge beats a clearing write in the same cycle.
  // ---------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < PIN_W; i++) begin
      if (pull_polarity_r[i]) begin
        edge_event[i] = pin_sync_r[i] && !pin_prev_r[i];
      end else begin
        edge_event[i] = !pin_sync_r[i] && pin_prev_r[i];
      end
    end
    int_status_nxt = int_status_r;
    if (wr_int_status) begin
      int_status_nxt = int_status_r & ~to_pins(reg_wr_data);
    end
    int_status_nxt = int_status_nxt | (edge_event & interrupt_enable_r);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      int_status_r <= to_pins(ptp_pkg::RST_INT_STATUS);
    end else begin
      int_status_r <= int_status_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_status_nxt & interrupt_enable_r);
    end
  end

  // ---------------------------------------------------------------
  // Read mux. Pin values come from the synchroniser, so a direction
  // change shows in read data only after it settles.
  // ---------------------------------------------------------------
  always_comb begin
    unique case (reg_addr)
      ptp_pkg::OFS_OUTPUT_LATCH: begin
        rd_value = to_word((direction_r & output_latch_r)
                           | (~direction_r & pin_sync_r));
      end
      ptp_pkg::OFS_PIN_LEVEL: begin
        rd_value = to_word(pin_sync_r);
      end
      ptp_pkg::OFS_DIRECTION: begin
        rd_value = to_word(direction_r);
      end
      ptp_pkg::OFS_DRIVE_STRENGTH: begin
        rd_value = to_word(drive_strength_r);
      end
      ptp_pkg::OFS_PULL_ON: begin
        rd_value = to_word(pull_on_r);
      end
      ptp_pkg::OFS_PULL_POLARITY: begin
        rd_value = to_word(pull_polarity_r);
      end
      ptp_pkg::OFS_ROUTING: begin
        rd_value = '0;
        rd_value[ROUTE_W-1:0] = routing_r;
      end
      ptp_pkg::OFS_INT_ENABLE: begin
        rd_value = to_word(interrupt_enable_r);
      end
      ptp_pkg::OFS_INT_STATUS: begin
        rd_value = to_word(int_status_r);
      end
      default: begin
        rd_value = ptp_pkg::UNMAPPED_READ;
      end
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rd_data <= ptp_pkg::RST_READ_DATA;
    end else if (reg_rd_en) begin
      reg_rd_data <= rd_value;
    end else begin
      reg_rd_data <= ptp_pkg::RST_READ_DATA;
    end
  end

endmodule : ptp_port_t

// ==== ptp_port_t_monitor.sv ====
// Port-level assertions for the port T pin controller
`timescale 1ns/100ps

module ptp_port_t_monitor #(
  parameter int unsigned PIN_W   = 8,
  parameter int unsigned ROUTE_W = 5
) (
  // Clock and reset
  input wire logic               clk,
  input wire logic               sys_rst,
  // Register port
  input wire logic [7:0]         reg_addr,
  input wire logic [7:0]         reg_wr_data,
  input wire logic               reg_wr_en,
  input wire logic               reg_rd_en,
  input wire logic [7:0]         reg_rd_data,
  // Timer and PWM
  input wire logic [7:0]         timer_system_control,
  input wire logic [PIN_W-1:0]   timer_compare_select,
  input wire logic [PIN_W-1:0]   timer_overflow_toggle,
  input wire logic [PIN_W-1:0]   timer_output_action_high,
  input wire logic [PIN_W-1:0]   timer_output_action_low,
  input wire logic [PIN_W-1:0]   timer_channel_out,
  input wire logic [PIN_W-1:0]   timer_capture_in,
  input wire logic [ROUTE_W-1:0] pwm_channel_enable,
  input wire logic [ROUTE_W-1:0] pwm_channel_out,
  // Pads and interrupt
  input wire logic [PIN_W-1:0]   pin_in,
  input wire logic [PIN_W-1:0]   pin_out,
  input wire logic [PIN_W-1:0]   pin_oe,
  input wire logic [PIN_W-1:0]   pin_reduced_drive,
  input wire logic [PIN_W-1:0]   pin_pull_up_en,
  input wire logic [PIN_W-1:0]   pin_pull_down_en,
  input wire logic               irq
);
  logic [2:0] up_cnt_r;
  wire        gpio_only = !timer_system_control[7] && pwm_channel_enable == 5'h00;
  wire        dir_wr    = reg_wr_en && reg_addr == ptp_pkg::OFS_DIRECTION;
  wire        en_wr     = reg_wr_en && reg_addr == ptp_pkg::OFS_INT_ENABLE;
  wire        tmr7      = timer_system_control[7]
                          && (timer_compare_select[7] || timer_overflow_toggle[7])
                          && (timer_output_action_high[7] || timer_output_action_low[7]);

  default clocking mon_cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // Pin samples are trusted only once the synchroniser has refilled after reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      up_cnt_r <= 3'h0;
    end else if (up_cnt_r != 3'h7) begin
      up_cnt_r <= up_cnt_r + 3'h1;
    end
  end

  sequence s_pin_steady;
    (up_cnt_r == 3'h7 && $stable(pin_in)) [*4];
  endsequence
  sequence s_dir_settle;
    (dir_wr && gpio_only) ##1 (gpio_only && !dir_wr);
  endsequence
  sequence s_mask_off;
    (en_wr && reg_wr_data == 8'h00) ##1 !en_wr;
  endsequence

  AST_PULL_OFF_DRIVEN: assert property (
    (pin_oe & (pin_pull_up_en | pin_pull_down_en)) == 8'h00)
    else $error("Pull device on at a driven pin");
  AST_RDR_INPUT: assert property (
    (pin_reduced_drive & ~pin_oe) == 8'h00)
    else $error("Reduced drive on an undriven pin");
  AST_RD_IDLE: assert property (
    !reg_rd_en |=> reg_rd_data == 8'h00)
    else $error("Read data without a read strobe");
  AST_PIN_READ: assert property (
    s_pin_steady ##0 (reg_rd_en && reg_addr == ptp_pkg::OFS_PIN_LEVEL)
    |=> reg_rd_data == $past(pin_in))
    else $error("Pin level read differs from pins");
  AST_CAPTURE: assert property (
    s_pin_steady |-> timer_capture_in == pin_in)
    else $error("Capture input differs from pins");
  AST_IRQ_MASK: assert property (
    s_mask_off |=> !irq)
    else $error("Interrupt still high with all bits masked");
  AST_DIR_OE: assert property (
    s_dir_settle |=> pin_oe == $past(reg_wr_data, 2))
    else $error("Output enable does not follow direction");
  AST_TIMER_PIN7: assert property (
    tmr7 |=> pin_oe[7] && pin_out[7] == $past(timer_channel_out[7]))
    else $error("Active timer channel does not own its pin");

endmodule : ptp_port_t_monitor

bind ptp_port_t ptp_port_t_monitor #(.PIN_W(PIN_W), .ROUTE_W(ROUTE_W)) u_ptp_port_t_monitor (
  .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
  .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
  .timer_system_control(timer_system_control), .timer_compare_select(timer_compare_select),
  .timer_overflow_toggle(timer_overflow_toggle),
  .timer_output_action_high(timer_output_action_high),
  .timer_output_action_low(timer_output_action_low), .timer_channel_out(timer_channel_out),
  .timer_capture_in(timer_capture_in), .pwm_channel_enable(pwm_channel_enable),
  .pwm_channel_out(pwm_channel_out), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
  .pin_reduced_drive(pin_reduced_drive), .pin_pull_up_en(pin_pull_up_en),
  .pin_pull_down_en(pin_pull_down_en), .irq(irq)
);

// ==== tb_top.sv ====
// Register-level bench for the port T pin controller
`timescale 1ns/100ps

module tb_top;
  logic       clk, sys_rst, reg_wr_en, reg_rd_en, irq;
  logic [7:0] reg_addr, reg_wr_data, reg_rd_data, t_ctl, t_cmp, t_ovf, t_ah, t_al, t_out;
  logic [7:0] cap, pin_in, pin_out, pin_oe, reduced_drive_bit, pu, pd, ext, ext_en;
  logic [4:0] pwm_en, pwm_out;
  logic [7:0] rst_ofs [9] = '{8'h00, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07, 8'h10, 8'h11, 8'h06};
  int         failures = 0;
  int         cmp_count = 0;

  ptp_port_t u_ptp_port_t (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
    .timer_system_control(t_ctl), .timer_compare_select(t_cmp),
    .timer_overflow_toggle(t_ovf), .timer_output_action_high(t_ah),
    .timer_output_action_low(t_al), .timer_channel_out(t_out), .timer_capture_in(cap),
    .pwm_channel_enable(pwm_en), .pwm_channel_out(pwm_out), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_reduced_drive(reduced_drive_bit),
    .pin_pull_up_en(pu), .pin_pull_down_en(pd), .irq(irq)
  );

  ptp_pad_model u_ptp_pad_model (
    .clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_up_en(pu),
    .pin_pull_down_en(pd), .ext_drive(ext), .ext_en(ext_en), .pin_level(pin_in)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr_en   <= 1'b1;
    reg_addr    <= a;
    reg_wr_data <= v;
    @(posedge clk);
    reg_wr_en <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe, so it is sampled there
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd_en <= 1'b1;
    reg_addr  <= a;
    @(posedge clk);
    reg_rd_en <= 1'b0;
    #1;
    chk(reg_rd_data, exp);
  endtask : rc

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic await_irq(input logic exp);
    int n;
    n = 0;
    // Step off the clock edge so irq is looked at once it has settled
    #1;
    while (irq !== exp && n < 8) begin
      tick(1);
      n++;
    end
    chk({7'h00, irq}, {7'h00, exp});
    if (irq !== exp) begin
      results();
    end
  endtask : await_irq

  task automatic results;
    $display("Compares %0d, failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results

  initial begin
    sys_rst = 1'b1;
    {reg_wr_en, reg_rd_en, reg_addr, reg_wr_data} = 18'h00000;
    {t_ctl, t_cmp, t_ovf, t_ah, t_al, t_out} = 48'h000000000000;
    {pwm_en, pwm_out, ext, ext_en} = 26'h0000000;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (rst_ofs[i]) begin
      rc(rst_ofs[i], 8'h00);
    end
    chk(pin_oe | pu | pd, 8'h00);
    $display("Test 1 done: reset values");

    @(posedge clk);
    ext    <= 8'h5a;
    ext_en <= 8'h0f;
    wr(8'h04, 8'hff);
    wr(8'h05, 8'hf0);
    tick(3);
    chk(pu, 8'h0f);
    chk(pd, 8'hf0);
    wr(8'h00, 8'h33);
    wr(8'h03, 8'hff);
    wr(8'h02, 8'h3c);
    tick(3);
    chk(pin_oe, 8'h3c);
    chk(pin_out & pin_oe, 8'h30);
    chk(reduced_drive_bit, 8'h3c);
    chk(pu | pd, 8'hc3);
    rc(8'h00, 8'h32);
    rc(8'h01, 8'h3a);
    wr(8'h01, 8'hff);
    rc(8'h01, 8'h3a);
    chk(cap, 8'h3a);
    $display("Test 2 done: direction, pulls, drive");

    // Pin 1 falls, pin 0 rises against its falling select, output pin 4 rises
    wr(8'h10, 8'h13);
    @(posedge clk);
    ext <= 8'h59;
    wr(8'h00, 8'h23);
    wr(8'h00, 8'h33);
    await_irq(1'b1);
    tick(4);
    rc(8'h11, 8'h12);
    wr(8'h10, 8'h00);
    await_irq(1'b0);
    rc(8'h11, 8'h12);
    wr(8'h11, 8'h12);
    rc(8'h11, 8'h00);
    $display("Test 3 done: interrupts");

    wr(8'h07, 8'hff);
    rc(8'h07, 8'h1f);
    @(posedge clk);
    {t_ctl, t_cmp, t_ovf, t_al, t_ah, t_out} <= 48'h804380038080;
    pwm_en  <= 5'h01;
    pwm_out <= 5'h01;
    tick(2);
    chk(pin_oe, 8'hbf);
    chk(pin_out & 8'h83, 8'h81);
    rc(8'h02, 8'h3c);
    wr(8'h07, 8'h1e);
    tick(2);
    chk(pin_out & 8'h01, 8'h00);
    @(posedge clk);
    t_ctl  <= 8'h7f;
    pwm_en <= 5'h00;
    tick(2);
    chk(pin_oe, 8'h3c);
    $display("Test 4 done: pin ownership");
    results();
  end

endmodule : tb_top
